// File: capacitive_touch_count_processing_bench.sv
// Purpose: self-checking bench for ctp_touch
// Assumes: baseline 0 untouched, noise 2, hysteresis 2, finger 6
// Notes: results read up to four times until two snapshots agree
`timescale 1ns/1ps
`default_nettype none
module capacitive_touch_count_processing_bench;
    import ctp_pkg::*;
    typedef struct {logic [7:0] a; logic [31:0] d, m; logic [1:0] r;} ctp_exp_t;
    logic aclk = 1'b0;
    logic aresetn = 1'b0;
    ctp_axi_req_t rq = '{bready: 1'b1, rready: 1'b1, default: '0};
    ctp_axi_rsp_t rs;
    ctp_front_t fr;
    logic comp, touch_on, exp_on = 1'b0;
    logic [4:0] cap = 5'h00;
    logic [5:0] lag = 6'h00;
    logic [31:0] lf = 32'hFD4D, rd_v, raw, base, dif;
    ctp_exp_t q[$];
    int n_fail = 0;
    int compares = 0;
    int caps[8] = '{0, 4, 6, 16, 6, 12, 4, 0};
    int pick[5] = '{0, 4, 6, 12, 16};
    always #12.5 aclk = ~aclk;
    ctp_touch i_dut (.aclk(aclk), .aresetn(aresetn), .axi_req(rq),
        .axi_rsp(rs), .comp_in(comp), .front(fr), .touch_on(touch_on));
    ctp_front_model i_afe (.front(fr), .cap(cap), .lag_ns(lag),
        .comp_out(comp));
    task automatic chk(input string n, input logic [31:0] e, g);
        compares++;
        if (g !== e) begin
            n_fail++;
            $display("CHECK FAILED %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic stop_test;
        $display("compares %0d n_fail %0d", compares, n_fail);
        if (n_fail == 0 && compares > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    // answer watcher: each taken answer meets the oldest note
    always @(negedge aclk) begin
        ctp_exp_t e;
        if (rs.rvalid || rs.bvalid) begin
            e = q.pop_front();
            if (rs.rvalid) begin
                rd_v = rs.rdata;
                if (e.m != 0) chk($sformatf("rdata %h", e.a), e.d, rs.rdata & e.m);
            end
            chk($sformatf("resp %h", e.a), {30'h0, e.r},
                {30'h0, rs.rvalid ? rs.rresp : rs.bresp});
        end
    end
    // holds each offered channel until its ready, then waits the answer
    task automatic xfer;
        logic aw, w, ar, got;
        int t;
        t = 0;
        do begin
            @(negedge aclk);
            aw = rs.awready;
            w = rs.wready;
            ar = rs.arready;
            got = rs.rvalid || rs.bvalid;
            @(posedge aclk);
            // only lower a valid that is up, so a following call may raise it
            if (aw && rq.awvalid) rq.awvalid <= 1'b0;
            if (w && rq.wvalid) rq.wvalid <= 1'b0;
            if (ar && rq.arvalid) rq.arvalid <= 1'b0;
            t++;
        end while (!got && t < 500);
        if (!got) chk("bus answer", 32'h1, 32'h0);
    endtask
    // random source for the front end lag
    function automatic logic [31:0] lfsr_next(input logic [31:0] v);
        return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
    endfunction
    task automatic wr(input logic [7:0] a, input logic [31:0] d,
                      input logic [1:0] r);
        q.push_back('{a, d, 32'h0, r});
        rq.awaddr <= a;
        rq.wdata <= d;
        rq.wstrb <= 4'hF;
        rq.awvalid <= 1'b1;
        rq.wvalid <= 1'b1;
        xfer();
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] d, m,
                      input logic [1:0] r);
        q.push_back('{a, d, m, r});
        rq.araddr <= a;
        rq.arvalid <= 1'b1;
        xfer();
    endtask
    task automatic snap;
        logic [31:0] r0, b0, d0;
        for (int i = 0; i < 4; i++) begin
            rd(CTP_OFF_RAW, 0, 0, CTP_RESP_OK);
            r0 = rd_v;
            rd(CTP_OFF_BASE, 0, 0, CTP_RESP_OK);
            b0 = rd_v;
            rd(CTP_OFF_DIFF, 0, 0, CTP_RESP_OK);
            d0 = rd_v;
            if (i > 0 && r0 === raw && b0 === base && d0 === dif) break;
            raw = r0;
            base = b0;
            dif = d0;
        end
    endtask
    task automatic settle(input int c, input int n);
        cap <= 5'(c);
        lf = lfsr_next(lf);
        // under one clock, so each period's comparator bit is the one counted
        lag <= {2'b00, lf[3:0]};
        repeat (n) @(posedge aclk);
        snap();
    endtask
    function automatic logic [31:0] ctl(input int n, input logic dual);
        return 32'h0002_0201 | (32'(n) << CTP_CTRL_RES_LO) |
            (32'(dual) << CTP_CTRL_DUAL);
    endfunction
    // main sequence
    initial begin
        logic bad;
        repeat (6) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        rd(CTP_OFF_CTRL, CTP_CTRL_RST, 32'hFFFF_FFFF, CTP_RESP_OK);
        rd(CTP_OFF_THR, CTP_THR_RST, 32'hFFFF_FFFF, CTP_RESP_OK);
        rd(CTP_OFF_CUR, CTP_CUR_RST, 32'h0000_FFFF, CTP_RESP_OK);
        rd(CTP_OFF_STAT, 0, 32'h3F, CTP_RESP_OK);
        rd(8'h20, 0, 32'hFFFF_FFFF, CTP_RESP_ERR);
        wr(8'h24, 32'h1, CTP_RESP_ERR);
        wr(CTP_OFF_THR, 32'h0006_0202, CTP_RESP_OK);
        rd(CTP_OFF_THR, 32'h0006_0202, 32'hFFFF_FFFF, CTP_RESP_OK);
        wr(CTP_OFF_CTRL, ctl(4, 1'b0), CTP_RESP_OK);
        settle(2, 800);
        chk("drift baseline", 1, base);
        chk("quiet signal", 0, dif);
        settle(0, 800);
        for (int i = 0; i < 14; i++) begin
            settle(i < 8 ? caps[i] : pick[lf[15:8] % 5], 400);
            chk("baseline", 0, base);
            if (raw > base + 2) begin
                chk("signal", raw - base, dif);
                if (dif >= 8) exp_on = 1'b1;
                else if (dif <= 4) exp_on = 1'b0;
            end else begin
                chk("quiet signal", 0, dif);
                exp_on = 1'b0;
            end
            chk("touch state", {31'h0, exp_on}, {31'h0, touch_on});
        end
        for (int n = 3; n < 6; n++) begin
            wr(CTP_OFF_CTRL, ctl(n, 1'b0), CTP_RESP_OK);
            settle(16, 700);
            chk("full scale", (32'h1 << n) - 1, raw);
        end
        bad = 1'b0;
        wr(CTP_OFF_CTRL, ctl(4, 1'b0) | 32'h4, CTP_RESP_OK);
        for (int i = 0; i < 600 && !(rd_v[5] && i > 0); i++) begin
            rd(CTP_OFF_STAT, 0, 0, CTP_RESP_OK);
            bad = bad | (rd_v[2] & rd_v[3]);
        end
        chk("scan during conversion", 0, {31'h0, bad});
        chk("conversion done", 1, {31'h0, rd_v[5]});
        rd(CTP_OFF_VOLT, 0, 32'hFFFF_FC00, CTP_RESP_OK);
        wr(CTP_OFF_CUR, 32'h0000_0810, CTP_RESP_OK);
        wr(CTP_OFF_CTRL, ctl(4, 1'b1), CTP_RESP_OK);
        settle(16, 700);
        chk("dual offset", 1, {31'h0, raw == 8 || raw == 7});
        stop_test();
    end
    // watchdog
    initial begin
        repeat (60000) @(posedge aclk);
        n_fail++;
        stop_test();
    end
endmodule
`default_nettype wire

// File: ctp_front_model.sv
// Purpose: behavioural analog front end and sensor pad
// Assumes: one charge packet per sense period
// Notes: comparator duty is cap/16; lag_ns delays its answer
`timescale 1ns/1ps
`default_nettype none
module ctp_front_model (
    input wire ctp_pkg::ctp_front_t front,
    input wire logic [4:0] cap,
    input wire logic [5:0] lag_ns,
    output logic comp_out
);
    import ctp_pkg::*;
    int acc = 0;
    logic hit;
    initial comp_out = 1'b0;
    // more capacitance trips the comparator more often; 16 trips always
    always @(posedge front.phase_a) begin
        acc = acc + int'(cap);
        hit = (acc >= 16);
        if (hit) begin
            acc = acc - 16;
        end
        comp_out <= #(lag_ns) hit;
    end
    // a discharged modulator cap leaves the comparator low
    always @(posedge front.mod_discharge) begin
        comp_out <= #(lag_ns) 1'b0;
    end
endmodule
`default_nettype wire

// File: ctp_pkg.sv
// Purpose: shared constants and types for the touch count processor
// Assumes: 32-bit axi4-lite register access, 40 MHz aclk
// Notes: offsets are byte addresses of aligned words
package ctp_pkg;
    localparam logic [7:0] CTP_OFF_CTRL = 8'h00;
    localparam logic [7:0] CTP_OFF_THR = 8'h04;
    localparam logic [7:0] CTP_OFF_CUR = 8'h08;
    localparam logic [7:0] CTP_OFF_STAT = 8'h0C;
    localparam logic [7:0] CTP_OFF_RAW = 8'h10;
    localparam logic [7:0] CTP_OFF_BASE = 8'h14;
    localparam logic [7:0] CTP_OFF_DIFF = 8'h18;
    localparam logic [7:0] CTP_OFF_VOLT = 8'h1C;
    // ctrl fields
    localparam int CTP_CTRL_EN = 0;
    localparam int CTP_CTRL_DUAL = 1;
    localparam int CTP_CTRL_VREQ = 2;
    localparam int CTP_CTRL_RES_LO = 4;
    localparam int CTP_CTRL_DIV_LO = 8;
    localparam int CTP_CTRL_FLT_LO = 16;
    localparam logic [31:0] CTP_CTRL_RST = 32'h0002_0410;
    localparam logic [31:0] CTP_THR_RST = 32'h0514_0A28;
    localparam logic [31:0] CTP_CUR_RST = 32'h0000_0808;
    localparam int CTP_RAW_W = 16;
    localparam int CTP_VOLT_W = 10;
    localparam logic [1:0] CTP_RESP_OK = 2'h0;
    localparam logic [1:0] CTP_RESP_ERR = 2'h2;

    typedef struct packed {
        logic [7:0] awaddr;
        logic awvalid;
        logic [31:0] wdata;
        logic [3:0] wstrb;
        logic wvalid;
        logic bready;
        logic [7:0] araddr;
        logic arvalid;
        logic rready;
    } ctp_axi_req_t;

    typedef struct packed {
        logic awready;
        logic wready;
        logic [1:0] bresp;
        logic bvalid;
        logic arready;
        logic [31:0] rdata;
        logic [1:0] rresp;
        logic rvalid;
    } ctp_axi_rsp_t;

    typedef struct packed {
        logic phase_a;
        logic phase_b;
        logic mod_discharge;
    } ctp_front_t;
endpackage

// File: ctp_touch.sv
// Purpose: sense switch phases, raw count, baseline, signal, touch state
// Assumes: comparator bit from analog front end, async to aclk
// Notes: also gates a one-shot voltage conversion between scans
`timescale 1ns/1ps
`default_nettype none

// Notes on behaviour
// - two equal-rate, opposite, non-overlapping switch phases
// - resolution programmable up to sixteen bits
// - count rises with sensor capacitance
// - dual mode subtracts full scale times current ratio
// - baseline is low-pass filtered raw count
// - signal equals raw minus baseline
// - thresholds are offsets above baseline
// - above noise: freeze baseline, true signal
// - below noise: update baseline, signal zero
// - ON when signal at least finger plus hysteresis
// - OFF when signal at most finger minus hysteresis
// - voltage measurement only while no scan runs
module ctp_touch (
    input wire logic aclk,
    input wire logic aresetn,
    input wire ctp_pkg::ctp_axi_req_t axi_req,
    output ctp_pkg::ctp_axi_rsp_t axi_rsp,
    input wire logic comp_in,
    output ctp_pkg::ctp_front_t front,
    output logic touch_on
);
    import ctp_pkg::*;

    typedef enum logic [3:0] {
        ST_IDLE = 4'b0001,
        ST_SCAN = 4'b0010,
        ST_PROC = 4'b0100,
        ST_VOLT = 4'b1000
    } ctp_state_t;

    // saturating add into 17 bits then clamp to 16
    function automatic logic [15:0] sat_add(input logic [15:0] a,
                                            input logic [15:0] b);
        logic [16:0] s;
        s = {1'b0, a} + {1'b0, b};
        sat_add = s[16] ? 16'hFFFF : s[15:0];
    endfunction

    logic [31:0] ctrl_q, thr_q, cur_q;
    logic vreq_q;
    ctp_state_t st_q;
    logic comp_m_q, comp_s_q;
    logic [7:0] div_q;
    logic ph_q, ph_dead_q;
    logic [16:0] tick_q;
    logic [15:0] ones_q;
    logic [15:0] raw_q, base_q, diff_q;
    logic [23:0] base_acc_q;
    logic base_init_q, touch_q;
    logic [9:0] volt_q;
    logic [10:0] vtick_q;
    logic [9:0] vones_q;
    logic volt_done_q;

    // register bus state
    logic aw_hold_q, w_hold_q, bvalid_q, rvalid_q;
    logic [7:0] awaddr_q;
    logic [31:0] wdata_q, rdata_q;
    logic [3:0] wstrb_q;
    logic [1:0] bresp_q, rresp_q;

    // decoded configuration
    wire logic [4:0] res_raw = ctrl_q[CTP_CTRL_RES_LO +: 5];
    wire logic [4:0] res_bits = (res_raw > 5'h10) ? 5'h10 :
        ((res_raw == 5'h00) ? 5'h01 : res_raw);
    wire logic [16:0] full_scale = (17'h0_0001 << res_bits) - 17'h0_0001;
    wire logic [7:0] div_val = ctrl_q[CTP_CTRL_DIV_LO +: 8];
    wire logic [3:0] flt_sh = ctrl_q[CTP_CTRL_FLT_LO +: 4];
    wire logic [7:0] th_noise = thr_q[7:0];
    wire logic [7:0] th_hyst = thr_q[15:8];
    wire logic [15:0] th_finger = thr_q[31:16];
    wire logic [7:0] i_mod = cur_q[7:0];
    wire logic [7:0] i_comp = cur_q[15:8];

    // compensation offset: full scale * comp / mod, mod zero treated as 1
    wire logic [7:0] i_mod_nz = (i_mod == 8'h00) ? 8'h01 : i_mod;
    wire logic [24:0] comp_prod = {8'h00, full_scale} * {17'h0_0000, i_comp};
    wire logic [24:0] comp_off_w = comp_prod / {17'h0_0000, i_mod_nz};
    wire logic [15:0] comp_off = (comp_off_w > 25'h000_FFFF) ? 16'hFFFF :
        comp_off_w[15:0];
    wire logic dual = ctrl_q[CTP_CTRL_DUAL];
    wire logic [15:0] raw_new = !dual ? ones_q :
        ((ones_q > comp_off) ? ones_q - comp_off : 16'h0000);

    // thresholds relative to baseline, signal against them
    wire logic [15:0] noise_lvl = sat_add(base_q, {8'h00, th_noise});
    wire logic above_noise = raw_new > noise_lvl;
    wire logic [15:0] sig_true = (raw_new > base_q) ? raw_new - base_q :
        16'h0000;
    wire logic [16:0] on_lim = {1'b0, th_finger} + {9'h000, th_hyst};
    wire logic [16:0] off_lim = ({1'b0, th_finger} > {9'h000, th_hyst}) ?
        {1'b0, th_finger} - {9'h000, th_hyst} : 17'h0_0000;
    wire logic [23:0] base_tgt = {raw_new, 8'h00};
    wire logic [23:0] base_step = (base_tgt > base_acc_q) ?
        ((base_tgt - base_acc_q) >> flt_sh) :
        ((base_acc_q - base_tgt) >> flt_sh);
    wire logic [23:0] base_next = (base_tgt > base_acc_q) ?
        base_acc_q + base_step : base_acc_q - base_step;

    // ends after exactly full-scale periods; >= also ends a scan whose
    // resolution was lowered mid-way, which == would leave hanging
    wire logic scan_end = (st_q == ST_SCAN) && (tick_q >= full_scale);
    wire logic div_tc = (div_q == div_val);

    // sense clock divider with a dead cycle at each phase change
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            div_q <= 8'h00;
            ph_q <= 1'b0;
            ph_dead_q <= 1'b1;
        end else begin
            div_q <= div_tc ? 8'h00 : div_q + 8'h01;
            ph_dead_q <= div_tc || (st_q != ST_SCAN);
            if (div_tc) begin
                ph_q <= ~ph_q;
            end
        end
    end

    // phases never overlap: the dead cycle drops both outputs
    assign front.phase_a = (st_q == ST_SCAN) && !ph_dead_q && !ph_q;
    assign front.phase_b = (st_q == ST_SCAN) && !ph_dead_q && ph_q;
    assign front.mod_discharge = (st_q == ST_IDLE);

    // comparator synchroniser
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            comp_m_q <= 1'b0;
            comp_s_q <= 1'b0;
        end else begin
            comp_m_q <= comp_in;
            comp_s_q <= comp_m_q;
        end
    end

    // sequencer; voltage conversion only starts from idle
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            st_q <= ST_IDLE;
        end else begin
            case (st_q)
                ST_IDLE: begin
                    if (vreq_q) begin
                        st_q <= ST_VOLT;
                    end else if (ctrl_q[CTP_CTRL_EN] && div_tc && ph_q) begin
                        st_q <= ST_SCAN;
                    end
                end
                ST_SCAN: st_q <= scan_end ? ST_PROC : ST_SCAN;
                ST_PROC: st_q <= ST_IDLE;
                ST_VOLT: st_q <= (vtick_q == 11'h3FF) ? ST_IDLE : ST_VOLT;
                default: st_q <= ST_IDLE;
            endcase
        end
    end

    // modulator density: comparator high = more current drawn
    always_ff @(posedge aclk) begin
        if (!aresetn || st_q == ST_IDLE) begin
            tick_q <= 17'h0_0000;
            ones_q <= 16'h0000;
        end else if (st_q == ST_SCAN && div_q == 8'h00 && ph_q &&
            !scan_end) begin
            tick_q <= tick_q + 17'h0_0001;
            if (comp_s_q && ones_q != 16'hFFFF) begin
                ones_q <= ones_q + 16'h0001;
            end
        end
    end

    // baseline, signal and touch state at scan end
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            raw_q <= 16'h0000;
            base_acc_q <= 24'h00_0000;
            base_q <= 16'h0000;
            diff_q <= 16'h0000;
            base_init_q <= 1'b0;
            touch_q <= 1'b0;
        end else if (st_q == ST_PROC) begin
            raw_q <= raw_new;
            base_init_q <= 1'b1;
            if (!base_init_q) begin
                base_acc_q <= base_tgt;
                base_q <= raw_new;
                diff_q <= 16'h0000;
            end else if (above_noise) begin
                diff_q <= sig_true;
                if ({1'b0, sig_true} >= on_lim) begin
                    touch_q <= 1'b1;
                end else if ({1'b0, sig_true} <= off_lim) begin
                    touch_q <= 1'b0;
                end
            end else begin
                base_acc_q <= base_next;
                base_q <= base_next[23:8];
                diff_q <= 16'h0000;
                if (off_lim == 17'h0_0000 || 17'h0_0000 <= off_lim) begin
                    touch_q <= 1'b0;
                end
            end
        end
    end
    assign touch_on = touch_q;

    // voltage conversion: 10-bit count of comparator density
    always_ff @(posedge aclk) begin
        if (!aresetn || st_q != ST_VOLT) begin
            vtick_q <= 11'h000;
            vones_q <= 10'h000;
        end else begin
            vtick_q <= vtick_q + 11'h001;
            if (comp_s_q && vones_q != 10'h3FF) begin
                vones_q <= vones_q + 10'h001;
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            volt_q <= 10'h000;
            volt_done_q <= 1'b0;
        end else if (st_q == ST_VOLT && vtick_q == 11'h3FF) begin
            volt_q <= vones_q;
            volt_done_q <= 1'b1;
        end
    end

    // axi4-lite write path: address and data held independently
    wire logic aw_take = axi_req.awvalid && !aw_hold_q && !bvalid_q;
    wire logic w_take = axi_req.wvalid && !w_hold_q && !bvalid_q;
    wire logic wr_go = aw_hold_q && w_hold_q && !bvalid_q;
    wire logic wr_ctrl = wr_go && awaddr_q == CTP_OFF_CTRL;
    wire logic wr_thr = wr_go && awaddr_q == CTP_OFF_THR;
    wire logic wr_cur = wr_go && awaddr_q == CTP_OFF_CUR;
    wire logic wr_ok = wr_ctrl || wr_thr || wr_cur;
    wire logic [31:0] wmask = {{8{wstrb_q[3]}}, {8{wstrb_q[2]}},
        {8{wstrb_q[1]}}, {8{wstrb_q[0]}}};

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_hold_q <= 1'b0;
            w_hold_q <= 1'b0;
            bvalid_q <= 1'b0;
            awaddr_q <= 8'h00;
            wdata_q <= 32'h0000_0000;
            wstrb_q <= 4'h0;
            bresp_q <= CTP_RESP_OK;
        end else begin
            if (aw_take) begin
                aw_hold_q <= 1'b1;
                awaddr_q <= axi_req.awaddr;
            end
            if (w_take) begin
                w_hold_q <= 1'b1;
                wdata_q <= axi_req.wdata;
                wstrb_q <= axi_req.wstrb;
            end
            if (wr_go) begin
                aw_hold_q <= 1'b0;
                w_hold_q <= 1'b0;
                bvalid_q <= 1'b1;
                bresp_q <= wr_ok ? CTP_RESP_OK : CTP_RESP_ERR;
            end else if (bvalid_q && axi_req.bready) begin
                bvalid_q <= 1'b0;
            end
        end
    end

    // software registers; voltage request self-clears when run
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ctrl_q <= CTP_CTRL_RST;
            thr_q <= CTP_THR_RST;
            cur_q <= CTP_CUR_RST;
            vreq_q <= 1'b0;
        end else begin
            if (wr_ctrl) begin
                ctrl_q <= (ctrl_q & ~wmask) | (wdata_q & wmask);
            end
            if (wr_thr) begin
                thr_q <= (thr_q & ~wmask) | (wdata_q & wmask);
            end
            if (wr_cur) begin
                cur_q <= (cur_q & ~wmask) | (wdata_q & wmask);
            end
            if (wr_ctrl && wstrb_q[0] && wdata_q[CTP_CTRL_VREQ]) begin
                vreq_q <= 1'b1;
            end else if (st_q == ST_VOLT) begin
                vreq_q <= 1'b0;
            end
        end
    end

    // read path
    wire logic [31:0] stat_w = {26'h000_0000, volt_done_q, vreq_q,
        st_q == ST_VOLT, st_q == ST_SCAN, base_init_q, touch_q};
    wire logic [7:0] ra = axi_req.araddr;
    wire logic rd_hit = ra == CTP_OFF_CTRL || ra == CTP_OFF_THR ||
        ra == CTP_OFF_CUR || ra == CTP_OFF_STAT || ra == CTP_OFF_RAW ||
        ra == CTP_OFF_BASE || ra == CTP_OFF_DIFF || ra == CTP_OFF_VOLT;
    wire logic [31:0] rd_mux =
        (ra == CTP_OFF_CTRL) ? ctrl_q :
        (ra == CTP_OFF_THR) ? thr_q :
        (ra == CTP_OFF_CUR) ? cur_q :
        (ra == CTP_OFF_STAT) ? stat_w :
        (ra == CTP_OFF_RAW) ? {16'h0000, raw_q} :
        (ra == CTP_OFF_BASE) ? {16'h0000, base_q} :
        (ra == CTP_OFF_DIFF) ? {16'h0000, diff_q} :
        (ra == CTP_OFF_VOLT) ? {22'h00_0000, volt_q} : 32'h0000_0000;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rvalid_q <= 1'b0;
            rdata_q <= 32'h0000_0000;
            rresp_q <= CTP_RESP_OK;
        end else if (axi_req.arvalid && !rvalid_q) begin
            rvalid_q <= 1'b1;
            rdata_q <= rd_mux;
            rresp_q <= rd_hit ? CTP_RESP_OK : CTP_RESP_ERR;
        end else if (rvalid_q && axi_req.rready) begin
            rvalid_q <= 1'b0;
        end
    end

    assign axi_rsp.awready = !aw_hold_q && !bvalid_q;
    assign axi_rsp.wready = !w_hold_q && !bvalid_q;
    assign axi_rsp.bvalid = bvalid_q;
    assign axi_rsp.bresp = bresp_q;
    assign axi_rsp.arready = !rvalid_q;
    assign axi_rsp.rvalid = rvalid_q;
    assign axi_rsp.rdata = rdata_q;
    assign axi_rsp.rresp = rresp_q;
endmodule
`default_nettype wire

// File: ctp_touch_chk.sv
// Purpose: port-level checks for ctp_touch
// Assumes: one aclk domain, sync active-low reset
// Notes: register contents are judged by the bench
`timescale 1ns/1ps
`default_nettype none
module ctp_touch_chk (
    input wire logic aclk,
    input wire logic aresetn,
    input wire ctp_pkg::ctp_axi_req_t axi_req,
    input wire ctp_pkg::ctp_axi_rsp_t axi_rsp,
    input wire ctp_pkg::ctp_front_t front,
    input wire logic touch_on
);
    import ctp_pkg::*;
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    // switch phases: never together, a dead cycle at each hand-over
    a_phase_excl: assert property (!(front.phase_a && front.phase_b))
        else $error("switch phases overlap");
    a_gap_to_b: assert property ($rose(front.phase_b) |-> !$past(front.phase_a))
        else $error("no dead cycle before phase b");
    a_gap_to_a: assert property ($rose(front.phase_a) |-> !$past(front.phase_b))
        else $error("no dead cycle before phase a");
    a_idle_open: assert property (front.mod_discharge |-> !front.phase_a && !front.phase_b)
        else $error("switch closed while discharging");
    // every phase a is answered by a phase b of the same period, or by discharge, within 600 cycles
    a_phase_pair: assert property ($rose(front.phase_a) |->
        ##[1:600] (front.phase_b || front.mod_discharge))
        else $error("phase b missing after phase a");
    // bus answers: latency and holding
    a_read_lat: assert property (axi_req.arvalid && axi_rsp.arready |=>
        axi_rsp.rvalid)
        else $error("read answer late");
    a_read_hold: assert property (axi_rsp.rvalid && !axi_req.rready |=>
        axi_rsp.rvalid && $stable(axi_rsp.rdata))
        else $error("read answer dropped");
    a_write_block: assert property (axi_rsp.bvalid |->
        !axi_rsp.awready && !axi_rsp.wready)
        else $error("write taken while answer pending");
    a_reset_off: assert property ($rose(aresetn) |-> !touch_on)
        else $error("touch state not off after reset");
    c_touch_on: cover property ($rose(touch_on));
    c_touch_off: cover property ($fell(touch_on));
    c_phase: cover property ($rose(front.phase_a));
    c_slverr: cover property (axi_rsp.bvalid && axi_rsp.bresp == CTP_RESP_ERR);
endmodule
bind ctp_touch ctp_touch_chk i_chk (.aclk(aclk), .aresetn(aresetn),
    .axi_req(axi_req), .axi_rsp(axi_rsp), .front(front),
    .touch_on(touch_on));
`default_nettype wire
